// >>> logic/adc_ctrl_pkg.sv
// package: register map, fields, reset values and timing for the converter control block
package adc_ctrl_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0] OFF_RESULT_LO  = 4'h0;
    localparam logic [3:0] OFF_RESULT_HI  = 4'h4;
    localparam logic [3:0] OFF_CONTROL    = 4'h8;
    localparam logic [3:0] OFF_CLOCK_SEL  = 4'hc;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFF_IRQ_MASK   = 5'h14;
    // control fields
    localparam int CTL_CHAN_LSB  = 0;
    localparam int CTL_PCFG_LSB  = 3;
    localparam int CTL_PEND_BIT  = 6;
    localparam int CTL_START_BIT = 7;
    // clock select fields
    localparam int CLK_SEL_LSB  = 0;
    localparam int CLK_TEST_BIT = 7;
    localparam logic [1:0] DIV_BY_2  = 2'h0;
    localparam logic [1:0] DIV_BY_8  = 2'h1;
    localparam logic [1:0] DIV_BY_32 = 2'h2;
    localparam logic [5:0] DIV2_HALF  = 6'h01;
    localparam logic [5:0] DIV8_HALF  = 6'h04;
    localparam logic [5:0] DIV32_HALF = 6'h10;
    // result bit 0 sits in bit 7 of the low result byte
    localparam int RES_LO_BIT = 7;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] CLOCK_RST   = 8'h00;
    localparam logic [0:0] MASK_RST    = 1'h0;
    // converter clocks per conversion
    localparam logic [4:0] CONV_CLOCKS = 5'h0a;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RESET = 2'b01,
        ST_CONV  = 2'b10
    } conv_state_t;
endpackage : adc_ctrl_pkg

// >>> logic/adc_clock_and_conversion_control.sv
// converter clock divider, start sequencing, pending flag, result capture and wishbone slave
// Contract
// - clock select 00/01/10 divides by 2/8/32
// - clock register bits 6:2 read zero
// - control 00100000 makes all pins analog, channel 0
// - clock 00000001 selects divide by eight
// - pending set on start rise, cleared at end
// - high byte bits 8:1, low bit7 holds 0
// - control bits 2:0 choose channel 0..3
// - control bits 5:3 set analog pin count
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_and_conversion_control #(
    parameter int RES_W = 9
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [4:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    // analog front end
    input  wire logic [RES_W-1:0] sample_i,
    output logic      [1:0]       channel_o,
    output logic      [3:0]       analog_pins_o,
    output logic                  powered_o,
    output logic                  sample_clk_o,
    // interrupt
    output logic                  irq_o
);
    adc_ctrl_pkg::conv_state_t state, next_state;
    logic [7:0]       control, next_control;
    logic [7:0]       clock_sel, next_clock_sel;
    logic [RES_W-1:0] result, next_result;
    logic             irq_status, next_irq_status;
    logic             irq_mask, next_irq_mask;
    logic [5:0]       div_cnt, next_div_cnt;
    logic             tick;
    logic             next_sample_clk;
    logic [4:0]       conv_cnt, next_conv_cnt;
    logic [31:0]      next_dat;
    logic             next_ack;
    logic [1:0]       next_channel;
    logic [3:0]       next_pins;
    logic             wr;
    logic             done;
    logic [5:0]       half;

    // a write lands on the edge that takes the request; at the ack edge
    // ack_o is already high, so the same request cannot write twice
    // writes without the low byte lane are dropped: every register is one byte
    assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

    // divider: half period from the select code; code 11 treated as /32 but must not be used
    always_comb begin
        case (clock_sel[adc_ctrl_pkg::CLK_SEL_LSB +: 2])
            adc_ctrl_pkg::DIV_BY_2:  half = adc_ctrl_pkg::DIV2_HALF;
            adc_ctrl_pkg::DIV_BY_8:  half = adc_ctrl_pkg::DIV8_HALF;
            adc_ctrl_pkg::DIV_BY_32: half = adc_ctrl_pkg::DIV32_HALF;
            default:                 half = adc_ctrl_pkg::DIV32_HALF;
        endcase
        tick = 1'b0;
        next_div_cnt = div_cnt + 6'h01;
        next_sample_clk = sample_clk_o;
        if (!powered_o) begin
            next_div_cnt = 6'h00;
            next_sample_clk = 1'b0;
        end else if (next_div_cnt >= half) begin
            next_div_cnt = 6'h00;
            next_sample_clk = !sample_clk_o;
            tick = sample_clk_o; // one tick per full converter clock
        end
    end

    // channel and pin decode
    // follows the stored control byte, so pins and power trail a write by a clock
    always_comb begin
        next_channel = control[adc_ctrl_pkg::CTL_CHAN_LSB +: 2];
        if (control[adc_ctrl_pkg::CTL_CHAN_LSB + 2]) begin
            next_channel = channel_o; // undefined codes keep the last channel
        end
        if (control[adc_ctrl_pkg::CTL_PCFG_LSB + 2]) begin
            next_pins = 4'hf;
        end else begin
            case (control[adc_ctrl_pkg::CTL_PCFG_LSB +: 2])
                2'h1:    next_pins = 4'h1;
                2'h2:    next_pins = 4'h3;
                2'h3:    next_pins = 4'h7;
                default: next_pins = 4'h0;
            endcase
        end
    end

    // conversion sequencing and register writes
    // pending bit is cleared by completion and re-armed by a later start rise,
    // so a restart in the completing cycle still reads as busy
    always_comb begin
        next_state = state;
        next_control = control;
        next_clock_sel = clock_sel;
        next_result = result;
        next_conv_cnt = conv_cnt;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        done = 1'b0;
        if (wr && adr_i == {1'b0, adc_ctrl_pkg::OFF_CLOCK_SEL}) begin
            next_clock_sel = {dat_i[7], 5'h00, dat_i[1:0]};
        end
        if (wr && adr_i == adc_ctrl_pkg::OFF_IRQ_MASK) begin
            next_irq_mask = dat_i[0];
        end
        if (wr && adr_i == {1'b0, adc_ctrl_pkg::OFF_CONTROL}) begin
            // pending flag is hardware owned
            next_control = {dat_i[7], control[6], dat_i[5:0]};
        end
        case (state)
            adc_ctrl_pkg::ST_IDLE: begin
                next_conv_cnt = 5'h00;
            end
            adc_ctrl_pkg::ST_RESET: begin
                // held in reset while start stays high
                if (!next_control[adc_ctrl_pkg::CTL_START_BIT]) begin
                    next_state = adc_ctrl_pkg::ST_CONV;
                end
            end
            adc_ctrl_pkg::ST_CONV: begin
                if (tick) begin
                    next_conv_cnt = conv_cnt + 5'h01;
                end
                if (tick && conv_cnt == adc_ctrl_pkg::CONV_CLOCKS - 5'h01) begin
                    done = 1'b1;
                    next_state = adc_ctrl_pkg::ST_IDLE;
                    next_result = sample_i;
                    next_control[adc_ctrl_pkg::CTL_PEND_BIT] = 1'b0;
                end
            end
            default: next_state = adc_ctrl_pkg::ST_IDLE;
        endcase
        // start rising resets the converter from any state and sets pending
        if (next_control[adc_ctrl_pkg::CTL_START_BIT] && !control[adc_ctrl_pkg::CTL_START_BIT]) begin
            next_state = adc_ctrl_pkg::ST_RESET;
            next_control[adc_ctrl_pkg::CTL_PEND_BIT] = 1'b1;
            next_conv_cnt = 5'h00;
        end
        // power off aborts; pending is left as it was, firmware must restart
        if (!powered_o) begin
            next_state = adc_ctrl_pkg::ST_IDLE;
        end
        if (wr && adr_i == adc_ctrl_pkg::OFF_IRQ_STATUS && dat_i[0]) begin
            next_irq_status = 1'b0;
        end
        if (done) begin
            next_irq_status = 1'b1; // set wins over a same-cycle clear
        end
    end

    // bus read path; ack rises one cycle after the request and drops the next
    // unmapped offsets read zero but are still acknowledged, so a stray
    // access never stalls the bus
    always_comb begin
        next_ack = cyc_i && stb_i && !ack_o;
        next_dat = 32'h0000_0000;
        case (adr_i)
            {1'b0, adc_ctrl_pkg::OFF_RESULT_LO}: next_dat[adc_ctrl_pkg::RES_LO_BIT] = result[0];
            {1'b0, adc_ctrl_pkg::OFF_RESULT_HI}: next_dat[7:0] = result[RES_W-1:1];
            {1'b0, adc_ctrl_pkg::OFF_CONTROL}:   next_dat[7:0] = control;
            {1'b0, adc_ctrl_pkg::OFF_CLOCK_SEL}: next_dat[7:0] = clock_sel;
            adc_ctrl_pkg::OFF_IRQ_STATUS:        next_dat[0] = irq_status;
            adc_ctrl_pkg::OFF_IRQ_MASK:          next_dat[0] = irq_mask;
            default:                             next_dat = 32'h0000_0000;
        endcase
    end

    // every output is a flip-flop; irq_o is fed from the next values so it
    // moves in the same clock as the status and mask bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= adc_ctrl_pkg::ST_IDLE;
            control       <= adc_ctrl_pkg::CONTROL_RST;
            clock_sel     <= adc_ctrl_pkg::CLOCK_RST;
            result        <= '0;
            irq_status    <= 1'b0;
            irq_mask      <= adc_ctrl_pkg::MASK_RST;
            div_cnt       <= 6'h00;
            sample_clk_o  <= 1'b0;
            conv_cnt      <= 5'h00;
            dat_o         <= 32'h0000_0000;
            ack_o         <= 1'b0;
            channel_o     <= 2'h0;
            analog_pins_o <= 4'h0;
            powered_o     <= 1'b0;
            irq_o         <= 1'b0;
        end else begin
            state         <= next_state;
            control       <= next_control;
            clock_sel     <= next_clock_sel;
            result        <= next_result;
            irq_status    <= next_irq_status;
            irq_mask      <= next_irq_mask;
            div_cnt       <= next_div_cnt;
            sample_clk_o  <= next_sample_clk;
            conv_cnt      <= next_conv_cnt;
            dat_o         <= next_dat;
            ack_o         <= next_ack;
            channel_o     <= next_channel;
            analog_pins_o <= next_pins;
            powered_o     <= (next_pins != 4'h0);
            irq_o         <= next_irq_status && next_irq_mask;
        end
    end
endmodule : adc_clock_and_conversion_control
`default_nettype wire

// >>> testbench/analog_source.sv
// analog front end model: presents a level per selected channel
`timescale 1ns/1ps
`default_nettype none
module analog_source (
    // converter side
    input  wire logic [1:0] channel_i,
    input  wire logic       powered_i,
    input  wire logic [8:0] level_i,
    output logic      [8:0] sample_o
);
    // unpowered inputs show garbage, not the last level
    assign sample_o = powered_i ? (level_i ^ {7'h00, channel_i}) : ~level_i;
endmodule : analog_source
`default_nettype wire

// >>> testbench/adc_ctrl_sva.sv
// checker: bus timing, readback and pin relations
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_sva (
    // bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [4:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pins
    input wire logic [1:0]  channel_o,
    input wire logic [3:0]  analog_pins_o,
    input wire logic        powered_o,
    input wire logic        sample_clk_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       take;
    logic       ctl_wr;
    logic [3:0] pins_exp;
    assign take = cyc_i && stb_i && !ack_o;
    assign ctl_wr = take && we_i && sel_i[0] && adr_i == 5'h08;
    assign pins_exp = dat_i[5] ? 4'hf : 4'((5'h01 << dat_i[4:3]) - 5'h01);
    a_ack_next: assert property (take |=> ack_o) else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_clk_unused: assert property (ack_o && $past(!we_i && adr_i == 5'h0c) |-> dat_o[6:2] == 5'h00)
        else $error("clock select unused bits set");
    a_lo_unused: assert property (ack_o && $past(!we_i && adr_i == 5'h00) |-> dat_o[6:0] == 7'h00)
        else $error("low result unused bits set");
    a_unmapped_zero: assert property (ack_o && $past(!we_i && adr_i > 5'h14) |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pins_power: assert property (powered_o == (analog_pins_o != 4'h0))
        else $error("power and pins disagree");
    a_pins_cfg: assert property (ctl_wr |-> ##2 analog_pins_o == $past(pins_exp, 2))
        else $error("pin config wrong");
    a_chan_cfg: assert property (ctl_wr && !dat_i[2] |-> ##2 channel_o == $past(dat_i[1:0], 2))
        else $error("channel wrong");
    a_clk_unpowered: assert property (!powered_o |=> !sample_clk_o)
        else $error("converter clock runs while unpowered");
endmodule : adc_ctrl_sva
bind adc_clock_and_conversion_control adc_ctrl_sva u_adc_ctrl_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .channel_o(channel_o), .analog_pins_o(analog_pins_o), .powered_o(powered_o), .sample_clk_o(sample_clk_o));
`default_nettype wire

// >>> testbench/test_adc_clock_and_conversion_control.sv
// bench: firmware-style register sequences against the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_clock_and_conversion_control;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [4:0]  adr_i = 5'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [3:0]  sel = 4'h1;
    logic [31:0] dat_o, q;
    logic        ack_o, powered_o, sample_clk_o, irq_o;
    logic [1:0]  channel_o;
    logic [3:0]  analog_pins_o;
    logic [8:0]  sample_i;
    logic [8:0]  level = 9'h000;
    logic        p;
    int          err_total = 0;
    int          compares = 0;
    int          n;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    adc_clock_and_conversion_control u_adc_clock_and_conversion_control (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sample_i(sample_i), .channel_o(channel_o), .analog_pins_o(analog_pins_o), .powered_o(powered_o),
        .sample_clk_o(sample_clk_o), .irq_o(irq_o));
    analog_source u_analog_source (.channel_i(channel_o), .powered_i(powered_o), .level_i(level), .sample_o(sample_i));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // holds the request until the edge that samples ack
    task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        sel_i <= sel;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task conv(input logic [7:0] ctl, input logic [7:0] hi);
        wb(1'b1, 5'h08, ctl);
        wb(1'b1, 5'h08, ctl | 8'h80);
        wb(1'b0, 5'h08, 8'h00);
        chk(q[6], 1'b1);
        wb(1'b1, 5'h08, ctl);
        wb(1'b0, 5'h04, 8'h00);
        chk(q, {24'h0, hi});
        do wb(1'b0, 5'h08, 8'h00); while (q[6] !== 1'b0);
    endtask : conv
    task end_sim;
        $display("mismatches %0d comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    initial begin
        #300us;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({irq_o, powered_o, analog_pins_o}, 32'h0);
        wb(1'b0, 5'h0c, 8'h00);
        chk(q, 32'h0);
        wb(1'b1, 5'h0c, 8'h7d);
        wb(1'b0, 5'h0c, 8'h00);
        chk(q, 32'h01);
        // codes with bit 2 set keep the last channel
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, 5'h08, 8'(i * 9));
            wb(1'b0, 5'h08, 8'h00);
            chk({channel_o, analog_pins_o}, {(i == 4) ? 2'h3 : 2'(i), (i == 4) ? 4'hf : 4'((1 << i) - 1)});
        end
        wb(1'b1, 5'h08, 8'h20);
        wb(1'b0, 5'h08, 8'h00);
        chk({q[7:0], channel_o, analog_pins_o, powered_o}, {8'h20, 2'h0, 4'hf, 1'b1});
        // half period of the converter clock, in system clocks, from a toggle on
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, 5'h0c, 8'(i));
            repeat (40) @(posedge clk_i);
            p = sample_clk_o;
            n = 0;
            while (sample_clk_o === p && n < 64) begin
                @(posedge clk_i);
                n++;
            end
            p = sample_clk_o;
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (sample_clk_o === p && n < 64);
            chk(n, 1 << (2 * i));
        end
        wb(1'b1, 5'h14, 8'h00);
        wb(1'b1, 5'h0c, 8'h01);
        level <= 9'h1a5;
        conv(8'h20, 8'h00);
        wb(1'b0, 5'h04, 8'h00);
        chk(q, 32'hd2);
        wb(1'b0, 5'h00, 8'h00);
        chk(q, 32'h80);
        wb(1'b0, 5'h10, 8'h00);
        chk({q[7:0], irq_o}, {8'h01, 1'b0});
        wb(1'b1, 5'h10, 8'h01);
        wb(1'b1, 5'h14, 8'h01);
        wb(1'b1, 5'h0c, 8'h00);
        level <= 9'h05a;
        conv(8'h22, 8'hd2);
        chk(irq_o, 1'b1);
        wb(1'b0, 5'h04, 8'h00);
        chk(q, 32'h2c);
        wb(1'b1, 5'h10, 8'h01);
        wb(1'b0, 5'h10, 8'h00);
        chk({q[7:0], irq_o}, 32'h0);
        // a write without the low byte lane must not land
        sel = 4'h2;
        wb(1'b1, 5'h0c, 8'h02);
        sel = 4'h1;
        wb(1'b0, 5'h0c, 8'h00);
        chk(q, 32'h0);
        wb(1'b1, 5'h18, 8'hff);
        wb(1'b0, 5'h18, 8'h00);
        chk(q, 32'h0);
        end_sim();
    end
endmodule : test_adc_clock_and_conversion_control
`default_nettype wire
